// file: design/spcg_consts.vh
// Constants for the sleep-mode port clock gating block
// How it works
// RULE1 - Each of ports A to H has its own sleep clock enable, port H at bit 7 down to port A at bit 0.
// RULE2 - A set enable keeps its port clocked during sleep so the port works normally.
// RULE3 - A clear enable stops its port clock during sleep and leaves the port disabled.
// RULE4 - A read or write aimed at a port whose clock is off gets a bus fault, not a normal finish.
// RULE5 - Reset clears every enable to zero, so every port starts unclocked.
// RULE6 - Bits 31 to 8 of the enable register are read-only, read as zero and ignore writes.
// RULE7 - Software keeps the reserved bits as read when it does a read-modify-write.
// RULE8 - The register at offset 0x118 is the source of port enables during sleep.
// RULE9 - Sleep enables replace run enables only while automatic gating is selected.
// RULE10 - Software must enable each port it needs before using it, since none is clocked at reset.
// RULE11 - An enable change reaches the port clock glitch-free, no earlier than the cycle after the write.
`ifndef SPCG_CONSTS_VH
`define SPCG_CONSTS_VH

// Byte offsets of the registers
`define SPCG_OFS_SLEEP_EN 12'h118
`define SPCG_OFS_FAULT_STAT 12'h200
`define SPCG_OFS_FAULT_MASK 12'h204
`define SPCG_OFS_ACTIVE_EN 12'h208

// Field layout of the enable byte
`define SPCG_PORT_A 0
`define SPCG_PORT_H 7
`define SPCG_NPORTS 8

// Reset values
`define SPCG_RST_SLEEP_EN 8'h00
`define SPCG_RST_FAULT_STAT 8'h00
`define SPCG_RST_FAULT_MASK 8'h00
`define SPCG_RST_DATA 32'h00000000

`endif

// file: design/spcg_top.v
// Sleep-mode port clock gating register with bus-fault check and fault interrupt
`timescale 1ns/10ps
`include "spcg_consts.vh"

module spcg_top #(
  parameter AW = 12
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire [AW-1:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // System power state and run-mode settings
  input wire sleep_i,
  input wire auto_clock_gating_select_i,
  input wire [7:0] run_port_clock_enables_i,
  // Accesses from the system bus towards the ports
  input wire port_req_i,
  input wire [2:0] port_idx_i,
  output reg port_done_o,
  output reg port_fault_o,
  // Per-port clock enables, for an integrated clock-gate cell per port
  output reg [7:0] port_clk_en_o,
  // Interrupt
  output reg irq_o
);

  reg [7:0] sleep_en_q;
  reg [7:0] fault_stat_q;
  reg [7:0] fault_mask_q;
  reg [7:0] sleep_en_d;
  reg [7:0] fault_stat_d;
  reg [7:0] fault_mask_d;
  reg [7:0] active_en;
  reg [7:0] fault_set;
  reg [31:0] rd_data;
  reg hit;
  wire req;
  wire wr_now;

  // Byte-address match on a full word, low two bits must be zero
  function match;
    input [AW-1:0] a;
    input [11:0] ofs;
    begin
      match = (a == ofs[AW-1:0]);
    end
  endfunction

  // Widens an 8-bit field to a bus word, upper bits zero
  function [31:0] word8;
    input [7:0] v;
    begin
      word8 = {24'h000000, v};
    end
  endfunction

  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  // Writes land at the edge where the master sees ack high
  assign wr_now = cyc_i & stb_i & we_i & ack_o & sel_i[0];

  // Enables in force now: sleep set only under automatic gating
  always @* begin
    if (sleep_i && auto_clock_gating_select_i) begin // see RULE9
      active_en = sleep_en_q; // see RULE2 see RULE3 see RULE8
    end else begin
      active_en = run_port_clock_enables_i;
    end
  end

  // Address decode and read mux
  always @* begin
    hit = 1'b1;
    rd_data = `SPCG_RST_DATA;
    if (match(adr_i, `SPCG_OFS_SLEEP_EN)) begin
      rd_data = word8(sleep_en_q); // see RULE6
    end else if (match(adr_i, `SPCG_OFS_FAULT_STAT)) begin
      rd_data = word8(fault_stat_q);
    end else if (match(adr_i, `SPCG_OFS_FAULT_MASK)) begin
      rd_data = word8(fault_mask_q);
    end else if (match(adr_i, `SPCG_OFS_ACTIVE_EN)) begin
      rd_data = word8(port_clk_en_o);
    end else begin
      hit = 1'b0;
    end
  end

  // A port access faults when that port is unclocked right now
  always @* begin
    fault_set = 8'h00;
    if (port_req_i && !port_clk_en_o[port_idx_i]) begin // see RULE4
      fault_set[port_idx_i] = 1'b1;
    end
  end

  // Next register values; only bits 7:0 are writable
  always @* begin
    sleep_en_d = sleep_en_q;
    fault_mask_d = fault_mask_q;
    fault_stat_d = fault_stat_q;
    if (wr_now && match(adr_i, `SPCG_OFS_SLEEP_EN)) begin
      sleep_en_d = dat_i[`SPCG_PORT_H:`SPCG_PORT_A]; // see RULE1 see RULE6
    end
    if (wr_now && match(adr_i, `SPCG_OFS_FAULT_MASK)) begin
      fault_mask_d = dat_i[7:0];
    end
    if (wr_now && match(adr_i, `SPCG_OFS_FAULT_STAT)) begin
      fault_stat_d = fault_stat_q & ~dat_i[7:0];
    end
    // A fault in the clearing cycle is kept
    fault_stat_d = fault_stat_d | fault_set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sleep_en_q <= `SPCG_RST_SLEEP_EN; // see RULE5
      fault_stat_q <= `SPCG_RST_FAULT_STAT;
      fault_mask_q <= `SPCG_RST_FAULT_MASK;
      port_clk_en_o <= `SPCG_RST_SLEEP_EN; // see RULE5
      port_done_o <= 1'b0;
      port_fault_o <= 1'b0;
      irq_o <= 1'b0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= `SPCG_RST_DATA;
    end else begin
      sleep_en_q <= sleep_en_d;
      fault_stat_q <= fault_stat_d;
      fault_mask_q <= fault_mask_d;
      // Registered enable changes only at a clock edge, so the gate cell never sees a
      // mid-cycle change; a write shows here one cycle after it lands
      port_clk_en_o <= active_en; // see RULE11
      port_done_o <= port_req_i & port_clk_en_o[port_idx_i];
      port_fault_o <= port_req_i & ~port_clk_en_o[port_idx_i]; // see RULE4
      irq_o <= |(fault_stat_d & fault_mask_d);
      ack_o <= req & hit;
      err_o <= req & ~hit;
      if (req) begin
        dat_o <= hit ? rd_data : `SPCG_RST_DATA;
      end
    end
  end

endmodule // spcg_top

// file: tb/spcg_chk.sv
// Assertions on the ports of the sleep-mode clock gating block
`timescale 1ns/10ps
module spcg_chk #(parameter AW = 12) (
  input logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, sleep_i, irq_o,
  input logic auto_clock_gating_select_i, port_req_i, port_done_o, port_fault_o,
  input logic [2:0] port_idx_i,
  input logic [7:0] run_port_clock_enables_i, port_clk_en_o,
  input logic [31:0] dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire gate_off = !port_clk_en_o[port_idx_i];
  chk_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
    else $error("no bus answer");
  chk_ack_pulse: assert property (ack_o || err_o |=> !ack_o && !err_o)
    else $error("answer too long");
  chk_resv_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("reserved bits set");
  chk_fault_gated: assert property (port_req_i && gate_off |=> port_fault_o && !port_done_o)
    else $error("no fault");
  chk_done_clocked: assert property (port_req_i && !gate_off |=> port_done_o && !port_fault_o)
    else $error("no done");
  chk_idle_port: assert property (!port_req_i |=> !port_done_o && !port_fault_o)
    else $error("stray answer");
  chk_run_follow: assert property (!$past(rst_i) && !$past(sleep_i && auto_clock_gating_select_i)
    |-> port_clk_en_o == $past(run_port_clock_enables_i)) else $error("run enables");
  chk_reset_clear: assert property ($past(rst_i) |-> port_clk_en_o == 8'h0 && !irq_o)
    else $error("not clear");
  cover property (port_fault_o);
  cover property (err_o);
  cover property (irq_o);
endmodule // spcg_chk
bind spcg_top spcg_chk #(.AW(AW)) chk_u (.*);

// file: tb/tb.sv
// Self-checking bench of the sleep-mode port clock gating block
`timescale 1ns/10ps
module tb;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, sleep_i = 1, port_req_i = 0;
  logic auto_clock_gating_select_i = 1, ack_o, err_o, port_done_o, port_fault_o, irq_o;
  logic [11:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, v;
  logic [3:0] sel_i = 4'hf;
  logic [7:0] run_port_clock_enables_i = 0, port_clk_en_o;
  logic [2:0] port_idx_i = 0;
  logic [32:0] q[$];
  logic pq[$];
  int err_total = 0, cmp_count = 0;
  spcg_top dut_u (.*);
  initial forever #2 clk_i = ~clk_i;
  task chk(input logic ok);
    cmp_count++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: mismatch", $time);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wb(input [11:0] a, input w, input [31:0] d, input [32:0] e);
    q.push_back(e);
    adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1; stb_i <= 1;
    // Look mid-cycle for the answer, then take it at the next rising edge
    @(negedge clk_i);
    while (!(ack_o | err_o)) @(negedge clk_i);
    @(posedge clk_i);
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask
  // Sampled mid-cycle so the edge's own updates have landed
  task ck(input [8:0] e);
    @(negedge clk_i);
    chk({irq_o, port_clk_en_o} === e);
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if ((ack_o | err_o) && q.size()) begin
      chk(err_o === q[0][32] && (we_i || dat_o === q[0][31:0]));
      void'(q.pop_front());
    end
    if ((port_done_o | port_fault_o) && pq.size()) begin
      chk(port_fault_o === pq[0] && port_done_o === !pq[0]);
      void'(pq.pop_front());
    end
  end
  initial begin
    v = $urandom(39522) & 32'hffff_fffe;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(12'h118, 0, 0, 0);
    wb(12'h118, 1, v, 0);
    wb(12'h118, 0, 0, {25'h0, v[7:0]});
    wb(12'h118, 1, {24'h0, v[7:0]}, 0);
    wb(12'h208, 0, 0, {25'h0, v[7:0]});
    for (int i = 0; i < 8; i++) begin
      pq.push_back(!v[i]);
      port_req_i <= 1;
      port_idx_i <= i[2:0];
      @(posedge clk_i);
    end
    port_req_i <= 0;
    ck({1'b0, v[7:0]});
    wb(12'h200, 0, 0, {25'h0, ~v[7:0]});
    wb(12'h204, 1, 32'hff, 0);
    ck({1'b1, v[7:0]});
    wb(12'h200, 1, 32'hff, 0);
    ck({1'b0, v[7:0]});
    wb(12'h11c, 0, 0, 33'h1_0000_0000);
    run_port_clock_enables_i <= 8'($urandom);
    auto_clock_gating_select_i <= 0;
    @(posedge clk_i);
    ck({1'b0, run_port_clock_enables_i});
    sleep_i <= 0;
    auto_clock_gating_select_i <= 1;
    @(posedge clk_i);
    ck({1'b0, run_port_clock_enables_i});
    sleep_i <= 1;
    @(posedge clk_i);
    ck({1'b0, v[7:0]});
    print_verdict;
  end
  initial begin
    #20000;
    err_total++;
    print_verdict;
  end
endmodule // tb
